// ==== src/hpir_defs.vh ====
// register offsets, field positions and reset values for the headphone impedance result control
`ifndef HPIR_DEFS_VH
`define HPIR_DEFS_VH
`define HPIR_ADDR_W 16
`define HPIR_WIDE_BASE 16'h3000
`define HPIR_CFG_ADDR 16'h0299
`define HPIR_CTRL_ADDR 16'h3000
`define HPIR_STAT_ADDR 16'h3004
`define HPIR_CAL_ADDR 16'h3008
`define HPIR_CFG_RESET 16'h0000
`define HPIR_OVD_BIT 15
`define HPIR_OUT_HI 14
`define HPIR_OUT_LO 12
`define HPIR_FRC_HI 11
`define HPIR_FRC_LO 8
`define HPIR_SNS_HI 7
`define HPIR_SNS_LO 4
`define HPIR_GND_HI 2
`define HPIR_GND_LO 0
`define HPIR_TRIG_BIT 0
`define HPIR_RANGE_HI 2
`define HPIR_RANGE_LO 1
`define HPIR_OUT_MAX 3'h5
`define HPIR_SNS_MAX 4'h9
`define HPIR_GND_MAX 3'h4
`define HPIR_SNS_HPDET1 4'h4
`define HPIR_SNS_HPDET2 4'h5
`define HPIR_CODE_MIN 10'h0a9
`define HPIR_CODE_MAX 10'h3fb
`define HPIR_MEAS_TMO 16'hffff
`endif

// ==== src/hpir_ctrl.v ====
// headphone impedance measurement control and result registers
//
// Local design decision: strobed register access.
`include "hpir_defs.vh"
module hpir_ctrl #(
   parameter CODE_W = 10,
   parameter LVL_W = 4,
   parameter [15:0] CAL_OFFSET = 16'h0000,
   parameter [15:0] CAL_SLOPE = 16'h0000
) (
   input wire clk,
   input wire rst_n,
   input wire [15:0] addr,
   input wire [31:0] wdata,
   input wire wr_en,
   input wire rd_en,
   output reg [31:0] rdata,
   output reg meas_start,
   output reg override_active,
   output reg [2:0] override_channel_sel,
   output reg [3:0] current_pin_sel,
   output reg [3:0] sense_pin_sel,
   output reg [2:0] ground_pin_sel,
   output reg [1:0] load_range_sel,
   output reg meas_event,
   input wire meas_done_in,
   input wire [CODE_W-1:0] result_code_in,
   input wire [LVL_W-1:0] level_in
);
   // **********************
   // state and decode helpers
   // **********************
   localparam ST_IDLE = 2'b01;
   localparam ST_BUSY = 2'b10;
   reg [1:0] state;
   reg [15:0] cfg;
   reg meas_complete_flag;
   reg [CODE_W-1:0] raw_result_code;
   reg [LVL_W-1:0] coarse_level;
   reg done_s1;
   reg done_s2;
   reg done_s3;
   reg done_prev;
   reg [15:0] tmo;
   wire wide;
   wire trig;
   wire done_edge;
   wire hp_sense;

   function is_wide;
      input [15:0] a;
      begin
         is_wide = (a >= `HPIR_WIDE_BASE);
      end
   endfunction

   // **********************
   // register writes
   // **********************
   assign wide = is_wide(addr);
   assign trig = wr_en && (addr == `HPIR_CTRL_ADDR) && wdata[`HPIR_TRIG_BIT];
   assign hp_sense = (cfg[`HPIR_SNS_HI:`HPIR_SNS_LO] == `HPIR_SNS_HPDET1) ||
      (cfg[`HPIR_SNS_HI:`HPIR_SNS_LO] == `HPIR_SNS_HPDET2);

   always @(posedge clk) begin
      if (!rst_n) begin
         cfg <= `HPIR_CFG_RESET;
         load_range_sel <= 2'b00;
      end else if (wr_en) begin
         if (addr == `HPIR_CFG_ADDR) begin
            cfg[15] <= wdata[`HPIR_OVD_BIT];
            if (wdata[`HPIR_OUT_HI:`HPIR_OUT_LO] <= `HPIR_OUT_MAX)
               cfg[14:12] <= wdata[`HPIR_OUT_HI:`HPIR_OUT_LO];
            cfg[11:8] <= wdata[`HPIR_FRC_HI:`HPIR_FRC_LO];
            if (wdata[`HPIR_SNS_HI:`HPIR_SNS_LO] <= `HPIR_SNS_MAX)
               cfg[7:4] <= wdata[`HPIR_SNS_HI:`HPIR_SNS_LO];
            if (wdata[`HPIR_GND_HI:`HPIR_GND_LO] <= `HPIR_GND_MAX)
               cfg[2:0] <= wdata[`HPIR_GND_HI:`HPIR_GND_LO];
         end else if (addr == `HPIR_CTRL_ADDR) begin
            load_range_sel <= wdata[`HPIR_RANGE_HI:`HPIR_RANGE_LO];
         end
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         override_channel_sel <= 3'h0;
         current_pin_sel <= 4'h0;
         sense_pin_sel <= 4'h0;
         ground_pin_sel <= 3'h0;
      end else begin
         override_channel_sel <= cfg[14:12];
         current_pin_sel <= cfg[11:8];
         sense_pin_sel <= cfg[7:4];
         ground_pin_sel <= cfg[2:0];
      end
   end

   // **********************
   // completion input synchroniser
   // **********************
   always @(posedge clk) begin
      if (!rst_n) begin
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
         done_s3 <= 1'b0;
         done_prev <= 1'b0;
      end else begin
         done_s1 <= meas_done_in;
         done_s2 <= done_s1;
         done_s3 <= done_s2;
         if (done_s2 == done_s3)
            done_prev <= done_s3;
      end
   end
   assign done_edge = (done_s2 == done_s3) && done_s3 && !done_prev;

   // **********************
   // measurement sequencer
   // **********************
   always @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         meas_start <= 1'b0;
         override_active <= 1'b0;
         meas_complete_flag <= 1'b0;
         raw_result_code <= {CODE_W{1'b0}};
         coarse_level <= {LVL_W{1'b0}};
         meas_event <= 1'b0;
         tmo <= 16'h0000;
      end else begin
         meas_start <= trig;
         meas_event <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (trig) begin
                  state <= ST_BUSY;
                  meas_complete_flag <= 1'b0;
                  override_active <= cfg[15];
                  tmo <= 16'h0000;
               end
            end
            ST_BUSY: begin
               tmo <= tmo + 16'h0001;
               if (done_edge || tmo == `HPIR_MEAS_TMO) begin
                  state <= ST_IDLE;
                  meas_complete_flag <= 1'b1;
                  override_active <= 1'b0;
                  if (hp_sense)
                     raw_result_code <= result_code_in;
                  else
                     raw_result_code <= {CODE_W{1'b0}};
                  coarse_level <= level_in;
                  meas_event <= 1'b1;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // **********************
   // register reads
   // **********************
   always @(posedge clk) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else if (rd_en) begin
         case (addr)
            `HPIR_CFG_ADDR: rdata <= {16'h0000, cfg[15:4], 1'b0, cfg[2:0]};
            `HPIR_CTRL_ADDR: rdata <= {29'h0000_0000, load_range_sel, 1'b0};
            `HPIR_STAT_ADDR: rdata <= {8'h00, {(8-LVL_W){1'b0}}, coarse_level,
               {(15-CODE_W){1'b0}}, raw_result_code, meas_complete_flag};
            `HPIR_CAL_ADDR: rdata <= {CAL_SLOPE, CAL_OFFSET};
            default: rdata <= 32'h0000_0000;
         endcase
         if (!wide)
            rdata[31:16] <= 16'h0000;
      end
   end
endmodule

// ==== bench/hpir_ctrl_properties.sv ====
// assertions on the impedance result control ports
module hpir_props (
   input logic clk,
   input logic rst_n,
   input logic [15:0] addr,
   input logic [31:0] wdata,
   input logic wr_en,
   input logic rd_en,
   input logic [31:0] rdata,
   input logic meas_start,
   input logic meas_event,
   input logic [2:0] override_channel_sel,
   input logic [3:0] sense_pin_sel,
   input logic [2:0] ground_pin_sel
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence trig_wr;
      wr_en && addr == 16'h3000 && wdata[0];
   endsequence
   sequence rd_at(logic [15:0] a);
      rd_en && addr == a;
   endsequence
   start_cause_a: assert property (meas_start |-> $past(wr_en && addr == 16'h3000 && wdata[0]))
      else $error("start without trigger");
   start_pulse_a: assert property (trig_wr ##1 meas_start |=> !meas_start)
      else $error("start too long");
   event_pulse_a: assert property (meas_event |=> !meas_event)
      else $error("event too long");
   narrow_read_a: assert property (rd_en && addr < 16'h3000 |=> rdata[31:16] == 16'h0000)
      else $error("upper half set");
   trig_clear_a: assert property (rd_at(16'h3000) |=> !rdata[0])
      else $error("trigger reads one");
   chan_code_a: assert property (override_channel_sel <= 3'h5)
      else $error("reserved channel");
   sense_code_a: assert property (sense_pin_sel <= 4'h9)
      else $error("reserved sense");
   gnd_code_a: assert property (ground_pin_sel <= 3'h4)
      else $error("reserved ground");
endmodule

// ==== bench/hpir_ctrl_test.sv ====
// self-checking bench for the impedance result control
module hpir_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, meas_done_in = 0;
   logic [15:0] addr = 16'h0000;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [9:0] code = 10'h000;
   logic [3:0] lvl = 4'h0, frc, sns;
   logic [2:0] och, gnd;
   logic [1:0] rng;
   logic ms, ovr, ev;
   int failures = 0, cmp_count = 0, i;
   always #50 clk = ~clk;
   hpir_ctrl #(.CAL_OFFSET(16'h1234), .CAL_SLOPE(16'h5678)) DUT (.clk(clk), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .meas_start(ms), .override_active(ovr), .override_channel_sel(och),
      .current_pin_sel(frc), .sense_pin_sel(sns), .ground_pin_sel(gnd),
      .load_range_sel(rng), .meas_event(ev), .meas_done_in(meas_done_in),
      .result_code_in(code), .level_in(lvl));
   // ****
   // bus, compare and finish tasks
   // ****
   task automatic stop_test;
      if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e, m = 32'hffff_ffff);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk("rdata", e, rdata & m);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(16'h0299, 32'h0000_0000);
      wr(16'h0299, 32'h0000_d444);
      rd(16'h0299, 32'h0000_d444);
      chk("fields", 32'h0000_2a24, {18'h0, och, frc, sns, gnd});
      wr(16'h0299, 32'h0000_e4a5);
      rd(16'h0299, 32'h0000_d444);
      wr(16'h3000, 32'h0000_0005);
      #1 chk("start", 32'h1, {31'h0, ms});
      chk("override", 32'h1, {31'h0, ovr});
      chk("range", 32'h2, {30'h0, rng});
      rd(16'h3000, 32'h0000_0004);
      rd(16'h3004, 32'h0000_0000);
      @(posedge clk);
      code <= 10'h3fb;
      lvl <= 4'h7;
      meas_done_in <= 1'b1;
      i = 0;
      while (ev !== 1'b1 && i < 10) begin
         @(posedge clk);
         #1 i++;
      end
      if (i == 10) begin
         failures++;
         stop_test();
      end
      chk("override", 32'h0, {31'h0, ovr});
      meas_done_in <= 1'b0;
      code <= 10'h000;
      rd(16'h3004, 32'h0007_07f7);
      rd(16'h3004, 32'h0007_07f7);
      wr(16'h3000, 32'h0000_0001);
      #1 chk("range", 32'h0, {30'h0, rng});
      rd(16'h3004, 32'h0000_0000, 32'h0000_0001);
      rd(16'h3008, 32'h5678_1234);
      rd(16'h0400, 32'h0000_0000);
      stop_test();
   end
endmodule
bind hpir_ctrl hpir_props u_props (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
   .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .meas_start(meas_start),
   .meas_event(meas_event), .override_channel_sel(override_channel_sel),
   .sense_pin_sel(sense_pin_sel), .ground_pin_sel(ground_pin_sel));
